//--- src/pwm3_timer_regs.vh
`ifndef PWM3_TIMER_REGS_VH
`define PWM3_TIMER_REGS_VH

// ----------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------
`define ADDR_RUN 8'h00
`define ADDR_FUNC 8'h04
`define ADDR_CNT 8'h08
`define ADDR_PERIOD 8'h0C
`define ADDR_NPHASE 8'h10
`define ADDR_CPEND 8'h14
`define ADDR_CPSTART 8'h18
`define ADDR_STATUS 8'h1C
`define ADDR_MASK 8'h20
`define ADDR_PEREN 8'h24

// ----------------------------------------------------------
// Field positions
// ----------------------------------------------------------
`define RUN_BIT 0
`define STOP_SEL_BIT 1
`define FUNC_EXT_EN_BIT 0
`define FUNC_OSC_OPT_BIT 1
`define FUNC_SRC_LSB 4
`define FUNC_SRC_MSB 6
`define PEREN_BIT 0
`define ST_MATCH_A 0
`define ST_MATCH_B 1
`define ST_MATCH_C 2
`define ST_MATCH_D 3
`define ST_OVF 4
`define ST_W 5

// ----------------------------------------------------------
// Count source codes
// ----------------------------------------------------------
`define SRC_SYS 3'h0
`define SRC_DIV2 3'h1
`define SRC_DIV4 3'h2
`define SRC_DIV8 3'h3
`define SRC_DIV32 3'h4
`define SRC_OSC 3'h5
`define SRC_EXT 3'h6

// ----------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------
`define CNT_W 16
`define CNT_MAX 16'hFFFF
`define CMP_RESET 16'hFFFF
`define DIV_W 5
`define CMP_N 4

`endif

//--- src/count_source_select.v
`timescale 1ns/1ps
`include "pwm3_timer_regs.vh"

module count_source_select (
    input wire clk,
    input wire reset,
    input wire [2:0] source_sel,
    input wire external_clock_enable,
    input wire oscillator_source_option,
    input wire high_speed_osc_clock,
    input wire external_count_input,
    output reg count_tick
);

// ----------------------------------------------------------
// Pin synchronisers and edge detect
// ----------------------------------------------------------
reg osc_s1_q, osc_s2_q, osc_s3_q;
reg ext_s1_q, ext_s2_q, ext_s3_q;
reg [`DIV_W-1:0] div_q;
wire osc_edge;
wire ext_edge;

always @(posedge clk) begin
    if (reset) begin
        osc_s1_q <= 1'b0;
        osc_s2_q <= 1'b0;
        osc_s3_q <= 1'b0;
        ext_s1_q <= 1'b0;
        ext_s2_q <= 1'b0;
        ext_s3_q <= 1'b0;
        div_q <= 5'h00;
    end else begin
        osc_s1_q <= high_speed_osc_clock;
        osc_s2_q <= osc_s1_q;
        osc_s3_q <= osc_s2_q;
        ext_s1_q <= external_count_input;
        ext_s2_q <= ext_s1_q;
        ext_s3_q <= ext_s2_q;
        div_q <= div_q + 5'h01;
    end
end

// Osc clock is only seen reliably if well below half of clk
assign osc_edge = osc_s2_q & ~osc_s3_q;
assign ext_edge = ext_s2_q & ~ext_s3_q;

// ----------------------------------------------------------
// Source multiplexer
// ----------------------------------------------------------
always @* begin
    case (source_sel)
        `SRC_SYS: count_tick = 1'b1;
        `SRC_DIV2: count_tick = &div_q[0:0];
        `SRC_DIV4: count_tick = &div_q[1:0];
        `SRC_DIV8: count_tick = &div_q[2:0];
        `SRC_DIV32: count_tick = &div_q[4:0];
        `SRC_OSC: count_tick = oscillator_source_option ? osc_edge : 1'b1;
        `SRC_EXT: count_tick = external_clock_enable & ext_edge;
        default: count_tick = 1'b0;
    endcase
end

endmodule // count_source_select

//--- src/two_output_nonoverlap_pwm_timer.v
// Summary of operation
// - Count source: system clock, dividers, oscillator
// - External input counts only when enabled
// - Only counter zero increments in this mode
// - Period is period compare plus one
// - Normal phase active period minus normal compare
// - Counter phase active end minus start
// - Writing run bit one starts counting when supply enable is set
// - Stop select one: stop on run clear
// - Stop select zero: stop at period match
// - Interrupt on any compare match or overflow
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pwm3_timer_regs.vh"

module two_output_nonoverlap_pwm_timer (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire high_speed_osc_clock,
    input wire external_count_input,
    output reg normal_phase_output,
    output reg counter_phase_output,
    output wire irq
);

// ----------------------------------------------------------
// Run state
// ----------------------------------------------------------
localparam [1:0] S_IDLE = 2'b01;
localparam [1:0] S_RUN = 2'b10;

reg [1:0] state_q;
reg [1:0] state_d;

// ----------------------------------------------------------
// Registers
// ----------------------------------------------------------
reg timer_clock_supply_enable_q;
reg channel0_stop_select_q;
reg external_clock_enable_q;
reg oscillator_source_option_q;
reg [2:0] source_sel_q;
reg [`CNT_W-1:0] counter_zero_q;
reg [`CNT_W-1:0] counter_zero_d;
reg [`CNT_W-1:0] period_compare_reg_q;
reg [`CNT_W-1:0] normal_phase_compare_reg_q;
reg [`CNT_W-1:0] counter_phase_end_reg_q;
reg [`CNT_W-1:0] counter_phase_start_reg_q;
reg [`ST_W-1:0] status_q;
reg [`ST_W-1:0] status_d;
reg [`ST_W-1:0] mask_q;
reg normal_d;
reg counter_d;
reg [`ST_W-1:0] mask_d;
reg [31:0] read_value;
reg irq_q;

wire access;
wire wr;
wire rd;
wire mapped;
wire count_tick;
wire running;
wire step;
wire match_a;
wire match_b;
wire match_c;
wire match_d;
wire overflow;
wire [`ST_W-1:0] events;
wire [`ST_W-1:0] clear_mask;
wire [`CMP_N*`CNT_W-1:0] cmp_values;
genvar gi;

// ----------------------------------------------------------
// Address decode
// ----------------------------------------------------------
function is_mapped;
    input [7:0] a;
    begin
        case (a)
            `ADDR_RUN, `ADDR_FUNC, `ADDR_CNT,
            `ADDR_PERIOD, `ADDR_NPHASE,
            `ADDR_CPEND, `ADDR_CPSTART,
            `ADDR_STATUS, `ADDR_MASK,
            `ADDR_PEREN: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    end
endfunction

function hit;
    input [7:0] a;
    input [7:0] reg_addr;
    begin
        hit = (a == reg_addr);
    end
endfunction

assign access = psel & penable;
assign mapped = is_mapped(paddr);
assign wr = access & pwrite & mapped;
// Read data is captured at the end of the setup phase
assign rd = psel & ~penable & ~pwrite & mapped;
// Zero wait states keep the slave simple
assign pready = 1'b1;
assign pslverr = access & ~mapped;

// ----------------------------------------------------------
// Count source
// ----------------------------------------------------------
count_source_select u_src (
    .clk(clk),
    .reset(reset),
    .source_sel(source_sel_q),
    .external_clock_enable(external_clock_enable_q),
    .oscillator_source_option(oscillator_source_option_q),
    .high_speed_osc_clock(high_speed_osc_clock),
    .external_count_input(external_count_input),
    .count_tick(count_tick)
);

// ----------------------------------------------------------
// Compare and step
// ----------------------------------------------------------
assign running = state_q[1];
// No supply enable, no counting: software must set it first
assign step = running & count_tick & timer_clock_supply_enable_q;

// Compare slots follow the status bit order A, B, C, D
assign cmp_values = {counter_phase_start_reg_q, normal_phase_compare_reg_q,
    counter_phase_end_reg_q, period_compare_reg_q};

generate
    for (gi = 0; gi < `CMP_N; gi = gi + 1) begin : g_cmp
        assign events[gi] = step & (counter_zero_q == cmp_values[gi*`CNT_W +: `CNT_W]);
    end
endgenerate

assign match_a = events[`ST_MATCH_A];
assign match_b = events[`ST_MATCH_B];
assign match_c = events[`ST_MATCH_C];
assign match_d = events[`ST_MATCH_D];
// Wrap past all ones, unless the period match clears the counter first
assign overflow = step & ~match_a & (counter_zero_q == `CNT_MAX);
assign events[`ST_OVF] = overflow;

assign clear_mask = (wr & hit(paddr, `ADDR_STATUS)) ? pwdata[`ST_W-1:0] : 5'h00;

// ----------------------------------------------------------
// Next state
// ----------------------------------------------------------
always @* begin
    state_d = state_q;
    case (state_q)
        S_IDLE: begin
            if (wr & hit(paddr, `ADDR_RUN) & pwdata[`RUN_BIT] & timer_clock_supply_enable_q) begin
                state_d = S_RUN;
            end
        end
        S_RUN: begin
            if (wr & hit(paddr, `ADDR_RUN) & ~pwdata[`RUN_BIT]) begin
                state_d = S_IDLE;
            end else if (match_a & ~channel0_stop_select_q) begin
                state_d = S_IDLE;
            end
        end
        default: state_d = S_IDLE;
    endcase
end

// ----------------------------------------------------------
// Counter and outputs
// ----------------------------------------------------------
always @* begin
    counter_zero_d = counter_zero_q;
    normal_d = normal_phase_output;
    counter_d = counter_phase_output;
    if (wr & hit(paddr, `ADDR_CNT)) begin
        counter_zero_d = pwdata[`CNT_W-1:0];
    end else if (match_a) begin
        counter_zero_d = 16'h0000;
    end else if (step) begin
        counter_zero_d = counter_zero_q + 16'h0001;
    end
    // Start match first, end match wins if both coincide
    if (match_c) begin
        normal_d = 1'b1;
    end
    if (match_a) begin
        normal_d = 1'b0;
    end
    if (match_d) begin
        counter_d = 1'b1;
    end
    if (match_b) begin
        counter_d = 1'b0;
    end
end

// ----------------------------------------------------------
// Interrupt status
// ----------------------------------------------------------
always @* begin
    // Set wins over a same-cycle write-one-to-clear
    status_d = (status_q & ~clear_mask) | events;
end

always @* begin
    mask_d = mask_q;
    if (wr & hit(paddr, `ADDR_MASK)) begin
        mask_d = pwdata[`ST_W-1:0];
    end
end

// ----------------------------------------------------------
// Interrupt output
// ----------------------------------------------------------
// Built from next values so the flop adds no latency yet cannot glitch
always @(posedge clk) begin
    if (reset) begin
        irq_q <= 1'b0;
    end else begin
        irq_q <= |(status_d & mask_d);
    end
end

assign irq = irq_q;

// ----------------------------------------------------------
// Register write
// ----------------------------------------------------------
always @(posedge clk) begin
    if (reset) begin
        state_q <= S_IDLE;
        timer_clock_supply_enable_q <= 1'b0;
        channel0_stop_select_q <= 1'b0;
        external_clock_enable_q <= 1'b0;
        oscillator_source_option_q <= 1'b0;
        source_sel_q <= `SRC_SYS;
        counter_zero_q <= 16'h0000;
        period_compare_reg_q <= `CMP_RESET;
        normal_phase_compare_reg_q <= `CMP_RESET;
        counter_phase_end_reg_q <= `CMP_RESET;
        counter_phase_start_reg_q <= `CMP_RESET;
        status_q <= 5'h00;
        mask_q <= 5'h00;
        normal_phase_output <= 1'b0;
        counter_phase_output <= 1'b0;
    end else begin
        state_q <= state_d;
        counter_zero_q <= counter_zero_d;
        status_q <= status_d;
        mask_q <= mask_d;
        // Outputs hold whatever level they had when counting stops
        normal_phase_output <= normal_d;
        counter_phase_output <= counter_d;
        if (wr) begin
            case (paddr)
                `ADDR_PEREN: begin
                    timer_clock_supply_enable_q <= pwdata[`PEREN_BIT];
                end
                `ADDR_RUN: begin
                    channel0_stop_select_q <= pwdata[`STOP_SEL_BIT];
                end
                `ADDR_FUNC: begin
                    external_clock_enable_q <= pwdata[`FUNC_EXT_EN_BIT];
                    oscillator_source_option_q <= pwdata[`FUNC_OSC_OPT_BIT];
                    source_sel_q <= pwdata[`FUNC_SRC_MSB:`FUNC_SRC_LSB];
                end
                `ADDR_PERIOD: begin
                    period_compare_reg_q <= pwdata[`CNT_W-1:0];
                end
                `ADDR_NPHASE: begin
                    normal_phase_compare_reg_q <= pwdata[`CNT_W-1:0];
                end
                `ADDR_CPEND: begin
                    counter_phase_end_reg_q <= pwdata[`CNT_W-1:0];
                end
                `ADDR_CPSTART: begin
                    counter_phase_start_reg_q <= pwdata[`CNT_W-1:0];
                end
                default: begin
                    // Mask, status and counter take their next values above
                end
            endcase
        end
    end
end

// ----------------------------------------------------------
// Register read
// ----------------------------------------------------------
always @* begin
    read_value = 32'h00000000;
    if (rd) begin
        case (paddr)
            `ADDR_PEREN: read_value[`PEREN_BIT] = timer_clock_supply_enable_q;
            `ADDR_RUN: begin
                read_value[`RUN_BIT] = running;
                read_value[`STOP_SEL_BIT] = channel0_stop_select_q;
            end
            `ADDR_FUNC: begin
                read_value[`FUNC_EXT_EN_BIT] = external_clock_enable_q;
                read_value[`FUNC_OSC_OPT_BIT] = oscillator_source_option_q;
                read_value[`FUNC_SRC_MSB:`FUNC_SRC_LSB] = source_sel_q;
            end
            `ADDR_CNT: read_value[`CNT_W-1:0] = counter_zero_q;
            `ADDR_PERIOD: read_value[`CNT_W-1:0] = period_compare_reg_q;
            `ADDR_NPHASE: read_value[`CNT_W-1:0] = normal_phase_compare_reg_q;
            `ADDR_CPEND: read_value[`CNT_W-1:0] = counter_phase_end_reg_q;
            `ADDR_CPSTART: read_value[`CNT_W-1:0] = counter_phase_start_reg_q;
            `ADDR_STATUS: read_value[`ST_W-1:0] = status_q;
            `ADDR_MASK: read_value[`ST_W-1:0] = mask_q;
            default: read_value = 32'h00000000;
        endcase
    end
end

// ----------------------------------------------------------
// Read data register
// ----------------------------------------------------------
always @(posedge clk) begin
    if (reset) begin
        prdata <= 32'h00000000;
    end else if (rd) begin
        prdata <= read_value;
    end else begin
        // Zero again once the access phase is over
        prdata <= 32'h00000000;
    end
end

endmodule // two_output_nonoverlap_pwm_timer

//--- tb/two_output_nonoverlap_pwm_timer_props.sv
`timescale 1ns/1ps
`include "pwm3_timer_regs.vh"

module pwm_timer_props (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire high_speed_osc_clock,
    input wire external_count_input,
    input wire normal_phase_output,
    input wire counter_phase_output,
    input wire irq
);
    // ----------------------------------------
    // Shadows of mask and supply enable
    // ----------------------------------------
    // Tracked from bus writes, so no internal signal is needed
    reg [4:0] mask_q;
    reg peren_q;
    wire acc = psel && penable;
    wire wr_hit = acc && pwrite;
    always @(posedge clk) begin
        if (reset) begin
            mask_q <= 5'h00;
            peren_q <= 1'b0;
        end else begin
            if (wr_hit && paddr == `ADDR_MASK) mask_q <= pwdata[4:0];
            if (wr_hit && paddr == `ADDR_PEREN) peren_q <= pwdata[0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_ready_always: assert property (pready) else $error("pready low");
    chk_reset_quiet: assert property (disable iff (1'b0) reset |=> !normal_phase_output && !counter_phase_output && !irq)
        else $error("outputs not low after reset");
    chk_rdata_idle: assert property (!acc |-> prdata == 32'h0000_0000) else $error("prdata outside access");
    chk_err_idle: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
    chk_unmapped_err: assert property (acc && paddr > `ADDR_PEREN |-> pslverr && prdata == 32'h0) else $error("no error");
    chk_mapped_ok: assert property (acc && paddr <= `ADDR_PEREN && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped address");
    chk_mask_clear: assert property (wr_hit && paddr == `ADDR_MASK && pwdata[4:0] == 5'h00 |=> !irq[*3])
        else $error("irq with zero mask");
    chk_irq_masked: assert property (mask_q == 5'h00 |-> !irq) else $error("irq while all masked");
    chk_hold_unpowered: assert property (!peren_q ##1 !peren_q |-> $stable(normal_phase_output) &&
        $stable(counter_phase_output)) else $error("outputs moved without supply");

    cover property ($rose(normal_phase_output));
    cover property ($rose(counter_phase_output));
    cover property ($rose(irq));
endmodule // pwm_timer_props

bind two_output_nonoverlap_pwm_timer pwm_timer_props pwm_timer_props_i (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .high_speed_osc_clock(high_speed_osc_clock), .external_count_input(external_count_input),
    .normal_phase_output(normal_phase_output), .counter_phase_output(counter_phase_output), .irq(irq));

//--- tb/test_two_output_nonoverlap_pwm_timer.sv
`timescale 1ns/1ps
`include "pwm3_timer_regs.vh"

module test_two_output_nonoverlap_pwm_timer;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic osc = 1'b0;
    logic ext = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, nph, cph, irq;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int a, b;
    logic [31:0] rv;
    logic ev;

    always #12.5 clk = ~clk;
    // Pin clocks: oscillator period 4 cycles, external pin period 6 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc % 2 == 1) osc <= ~osc;
        if (cyc % 3 == 2) ext <= ~ext;
        if (cyc == 60000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    two_output_nonoverlap_pwm_timer two_output_nonoverlap_pwm_timer_i (.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .high_speed_osc_clock(osc), .external_count_input(ext), .normal_phase_output(nph),
        .counter_phase_output(cph), .irq(irq));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Request stands until pready is seen high at a rising edge; the answer is taken at that edge
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
    endtask

    task automatic wait_lvl(input logic lvl, input logic cp, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while ((cp ? cph : nph) !== lvl && n < 4000);
    endtask

    task automatic setup(input logic [31:0] fw, input logic [31:0] run);
        wr(`ADDR_RUN, 32'h2);
        wr(`ADDR_FUNC, fw);
        wr(`ADDR_CNT, 32'h0);
        wr(`ADDR_RUN, run);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_and_unpowered;
        apb(1'b0, `ADDR_PERIOD, 0);
        chk(rv, 32'h0000FFFF);
        apb(1'b0, 8'h28, 0);
        chk(rv, 32'h0);
        chk(ev, 1'b1);
        wr(`ADDR_PERIOD, 32'h9);
        wr(`ADDR_RUN, 32'h3);
        repeat (10) @(posedge clk);
        apb(1'b0, `ADDR_CNT, 0);
        chk(rv, 32'h0);
    endtask

    task automatic t_waveform;
        wr(`ADDR_PEREN, 32'h1);
        wr(`ADDR_NPHASE, 32'h3);
        wr(`ADDR_CPEND, 32'h7);
        wr(`ADDR_CPSTART, 32'h2);
        setup(32'h00, 32'h3);
        wait_lvl(1'b1, 1'b0, a);
        wait_lvl(1'b0, 1'b0, b);
        chk(b, 6);
        wait_lvl(1'b1, 1'b0, a);
        chk(a + b, 10);
        wait_lvl(1'b0, 1'b1, a);
        wait_lvl(1'b1, 1'b1, a);
        wait_lvl(1'b0, 1'b1, b);
        chk(b, 5);
        apb(1'b0, `ADDR_STATUS, 0);
        chk(rv[3:0], 4'hF);
        wait_lvl(1'b1, 1'b0, a);
        wr(`ADDR_RUN, 32'h2);
        apb(1'b0, `ADDR_CNT, 0);
        b = rv;
        repeat (20) @(posedge clk);
        apb(1'b0, `ADDR_CNT, 0);
        chk(rv, b);
        chk(nph, 1'b1);
    endtask

    task automatic t_auto_stop;
        setup(32'h00, 32'h1);
        repeat (30) @(posedge clk);
        apb(1'b0, `ADDR_RUN, 0);
        chk(rv[0], 1'b0);
        apb(1'b0, `ADDR_CNT, 0);
        chk(rv, 32'h0);
        chk(nph, 1'b0);
    endtask

    task automatic t_sources;
        logic [31:0] fw [8] = '{32'h00, 32'h10, 32'h20, 32'h30, 32'h40, 32'h50, 32'h52, 32'h61};
        int fk [8] = '{1, 2, 4, 8, 32, 1, 4, 6};
        for (int i = 0; i < 8; i++) begin
            setup(fw[i], 32'h3);
            wait_lvl(1'b1, 1'b0, a);
            wait_lvl(1'b0, 1'b0, a);
            wait_lvl(1'b1, 1'b0, a);
            wait_lvl(1'b0, 1'b0, b);
            chk(a + b, 10 * fk[i]);
        end
        setup(32'h60, 32'h3);
        repeat (50) @(posedge clk);
        apb(1'b0, `ADDR_CNT, 0);
        chk(rv, 32'h0);
    endtask

    task automatic t_overflow_irq;
        setup(32'h00, 32'h2);
        wr(`ADDR_STATUS, 32'h1F);
        wr(`ADDR_MASK, 32'h10);
        chk(irq, 1'b0);
        wr(`ADDR_CNT, 32'hFFFA);
        wr(`ADDR_RUN, 32'h3);
        repeat (12) @(posedge clk);
        #1;
        chk(irq, 1'b1);
        apb(1'b0, `ADDR_STATUS, 0);
        chk(rv[4], 1'b1);
        wr(`ADDR_RUN, 32'h2);
        wr(`ADDR_STATUS, 32'h1F);
        #1;
        chk(irq, 1'b0);
        wr(`ADDR_MASK, 32'h0);
    endtask

    task automatic tally_and_finish;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_reset_and_unpowered();
        t_waveform();
        t_auto_stop();
        t_sources();
        t_overflow_irq();
        tally_and_finish();
    end
endmodule // test_two_output_nonoverlap_pwm_timer
